// ===== design/ssf_defines.svh
`ifndef SSF_DEFINES_SVH
`define SSF_DEFINES_SVH
// What this block does
// - Receive into a full buffer overwrites newest entry, status marked overrun.
// - Overrun flag rises once the overwriting character sits in the buffer.
// - Reception continues after overrun; flag clears only by writing one or reset.
// - Underrun: shifter and buffer empty, no end command; byte mode then idles.
// - Idle sends mark when idle select is 0, else repeats the idle pattern.
// - Byte-mode underrun sends CRC first only if starve control and CRC enable.
// - Leaving underrun idle needs the starve flag cleared and new data written.
// - Underrun sets starve flag and drops ready; clears by writing one or reset.
// - Message ends on end command, or on underrun with starve control set.
// - At message end append CRC when enabled, then idle; else idle directly.
// - Byte mode receiver never detects a message end.
// - HDLC data fields go out LSB first, the FCS MSB first.
// - No residual frames sent; received residual bits left-justified, marked.
// - HDLC frame boundaries come only from the flag 01111110.
// - Transmitter inserts a zero after five ones inside the frame.
// - Receiver drops a zero after five ones; six or more ones mean flag or abort.
// - Resets or transmit reset put HDLC transmitter in disable: mark, not ready.
// - Enable moves disable to idle; data written in idle starts opening flag.
// - One opening flag, then buffered characters, then FCS when enabled.
// - Frames end with a closing flag unless aborted; frames split by closing and opening flag.
// - Abort sends nine ones and then moves on.
// - HDLC underrun with starve control aborts then idles; else closes normally.
// - Transmit CRC covers field bits before zero insertion.

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SSF_OFF_CTRL    8'h00
`define SSF_OFF_MODE    8'h04
`define SSF_OFF_CMD     8'h08
`define SSF_OFF_IDLE    8'h0c
`define SSF_OFF_SYNC    8'h10
`define SSF_OFF_TXDATA  8'h14
`define SSF_OFF_ST0     8'h18
`define SSF_OFF_ST1     8'h1c
`define SSF_OFF_ST2     8'h20
`define SSF_OFF_RXDATA  8'h24

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define SSF_CTRL_IDLE_SEL 0
`define SSF_CTRL_STARVE   1
`define SSF_MODE_PROTO_LO 0
`define SSF_MODE_PROTO_HI 2
`define SSF_MODE_CRC_EN   3
`define SSF_PROTO_BIT     3'h2
`define SSF_CMD_TX_RST    0
`define SSF_CMD_TX_EN     1
`define SSF_CMD_EOM       2
`define SSF_CMD_CH_RST    3
`define SSF_ST0_TX_READY  0
`define SSF_ST0_RX_AVAIL  1
`define SSF_ST1_STARVE    0
`define SSF_ST2_OVERFLOW  0
`define SSF_RXD_OVR       8
`define SSF_RXD_EOF       9
`define SSF_RXD_RESIDUAL_BITS_FLAG      10
`define SSF_RXD_VALID     31
`define SSF_CTRL_RST      2'h0
`define SSF_MODE_RST      4'h0
`define SSF_IDLE_RST      8'hff
`define SSF_SYNC_RST      8'h96

// ----------------------------------------------------------------
// Line patterns and counts
// ----------------------------------------------------------------
`define SSF_FLAG          8'h7e
`define SSF_ABORT         16'h01ff
`define SSF_ABORT_LEN     5'h09
`define SSF_BYTE_LEN      5'h08
`define SSF_FCS_LEN       5'h10
`define SSF_CRC_INIT      16'hffff
`define SSF_CRC_POLY      16'h1021
`define SSF_STUFF_RUN     3'h5
`define SSF_FLAG_RUN      3'h6
`endif

// ===== design/ssf_pkg.sv
package ssf_pkg;
  typedef enum logic [2:0] {
    SSF_TX_DIS, SSF_TX_IDLE, SSF_TX_SYN, SSF_TX_OFLAG,
    SSF_TX_CHAR, SSF_TX_FCS, SSF_TX_CFLAG, SSF_TX_ABORT
  } ssf_tx_state_e;
  typedef enum logic {SSF_RX_HUNT, SSF_RX_DATA} ssf_rx_state_e;
  typedef logic [2:0] ssf_rx_stat_t;  // {residual, end of frame, overrun}
endpackage : ssf_pkg

// ===== design/ssf_framer.sv
`timescale 1ns/1ps
`include "ssf_defines.svh"
module ssf_framer #(
  parameter int BIT_DIV  = 8,
  parameter int RX_DEPTH = 4
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_rxd,
  output logic             o_txd
);
  localparam int PW = $clog2(RX_DEPTH);
  initial
  begin
    if (BIT_DIV < 2 || RX_DEPTH < 2 || (1 << PW) != RX_DEPTH)
      $error("ssf_framer: BIT_DIV must be >= 2, RX_DEPTH a power of two >= 2");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] crc_bit(input logic [15:0] c, input logic b);
    logic fb;
    fb = c[15] ^ b;
    crc_bit = {c[14:0], 1'b0} ^ (fb ? `SSF_CRC_POLY : 16'h0000);
  endfunction : crc_bit

  function automatic logic [15:0] rev16(input logic [15:0] v);
    rev16 = '0;
    for (int k = 0; k < 16; k++) rev16[k] = v[15 - k];
  endfunction : rev16

  // ----------------------------------------------------------------
  // APB decode and registers
  // ----------------------------------------------------------------
  logic [1:0]  ctrl_reg;
  logic [3:0]  mode_reg;
  logic [7:0]  idle_pattern_reg;
  logic [7:0]  sync_reg;
  logic        tx_starve_flag;
  logic        rx_overflow_flag;
  logic        tx_ready_flag;
  logic        apb_wr;
  logic        apb_rd;
  logic        mapped;
  logic        hdlc;
  logic        crc_en;
  logic        cmd_wr;
  logic        tx_rst;
  logic        ch_rst;
  logic        tx_en;
  logic        eom_cmd;
  logic        txd_wr;
  logic        rx_pop;
  logic        ovr_set;
  logic [31:0] rd_mux;
  logic [7:0]  fifo_d [RX_DEPTH];
  ssf_pkg::ssf_rx_stat_t fifo_s [RX_DEPTH];
  logic [PW-1:0] rp;
  logic [PW-1:0] wp;
  logic [PW:0]   fcnt;
  ssf_pkg::ssf_tx_state_e tx_state_reg;
  ssf_pkg::ssf_tx_state_e tx_next;
  logic        tbuf_full;

  assign apb_wr   = i_psel && i_penable && i_pwrite;
  assign apb_rd   = i_psel && i_penable && !i_pwrite;
  assign hdlc     = mode_reg[`SSF_MODE_PROTO_HI:`SSF_MODE_PROTO_LO] == `SSF_PROTO_BIT;
  assign crc_en   = mode_reg[`SSF_MODE_CRC_EN];
  assign cmd_wr   = apb_wr && i_paddr == `SSF_OFF_CMD;
  assign ch_rst   = cmd_wr && i_pwdata[`SSF_CMD_CH_RST];
  assign tx_rst   = ch_rst || (cmd_wr && i_pwdata[`SSF_CMD_TX_RST]);
  assign tx_en    = cmd_wr && i_pwdata[`SSF_CMD_TX_EN];
  assign eom_cmd  = cmd_wr && i_pwdata[`SSF_CMD_EOM];
  assign txd_wr   = apb_wr && i_paddr == `SSF_OFF_TXDATA;
  assign rx_pop   = apb_rd && i_paddr == `SSF_OFF_RXDATA && fcnt != '0;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !mapped;

  // Not ready while disabled, full, or starved so stale data cannot start a frame
  assign tx_ready_flag = tx_state_reg != ssf_pkg::SSF_TX_DIS && !tbuf_full && !tx_starve_flag;

  // Read mux; data is latched in the setup cycle so the access phase needs no wait
  always_comb
  begin
    mapped = 1'b1;
    rd_mux = '0;
    case (i_paddr)
      `SSF_OFF_CTRL:   rd_mux[1:0] = ctrl_reg;
      `SSF_OFF_MODE:   rd_mux[3:0] = mode_reg;
      `SSF_OFF_CMD:    rd_mux = '0;
      `SSF_OFF_IDLE:   rd_mux[7:0] = idle_pattern_reg;
      `SSF_OFF_SYNC:   rd_mux[7:0] = sync_reg;
      `SSF_OFF_TXDATA: rd_mux = '0;
      `SSF_OFF_ST0:
      begin
        rd_mux[`SSF_ST0_TX_READY] = tx_ready_flag;
        rd_mux[`SSF_ST0_RX_AVAIL] = fcnt != '0;
      end
      `SSF_OFF_ST1:    rd_mux[`SSF_ST1_STARVE] = tx_starve_flag;
      `SSF_OFF_ST2:    rd_mux[`SSF_ST2_OVERFLOW] = rx_overflow_flag;
      `SSF_OFF_RXDATA:
      begin
        rd_mux[7:0] = fifo_d[rp];
        rd_mux[`SSF_RXD_RESIDUAL_BITS_FLAG:`SSF_RXD_OVR] = fifo_s[rp];
        rd_mux[`SSF_RXD_VALID] = fcnt != '0;
      end
      default:         mapped = 1'b0;
    endcase
  end

  // Read data register
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
      o_prdata <= '0;
    else if (i_psel && !i_penable)
      o_prdata <= rd_mux;
  end

  // Control registers
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      ctrl_reg         <= `SSF_CTRL_RST;
      mode_reg         <= `SSF_MODE_RST;
      idle_pattern_reg <= `SSF_IDLE_RST;
      sync_reg         <= `SSF_SYNC_RST;
    end
    else if (apb_wr)
    begin
      case (i_paddr)
        `SSF_OFF_CTRL: ctrl_reg <= i_pwdata[1:0];
        `SSF_OFF_MODE: mode_reg <= i_pwdata[3:0];
        `SSF_OFF_IDLE: idle_pattern_reg <= i_pwdata[7:0];
        `SSF_OFF_SYNC: sync_reg <= i_pwdata[7:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Bit rate enable
  // ----------------------------------------------------------------
  logic [15:0] div_cnt;
  logic        tick;
  assign tick = div_cnt == 16'(BIT_DIV - 1);
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset || tick)
      div_cnt <= '0;
    else
      div_cnt <= div_cnt + 16'h0001;
  end

  // ----------------------------------------------------------------
  // Transmit buffer and flags
  // ----------------------------------------------------------------
  logic [7:0]  tbuf;
  logic        tbuf_last;
  logic        eom_arm;
  logic        take;
  logic        unit_end;
  logic        underrun;
  logic        cur_last;

  // One-deep buffer; a write is refused while full or disabled
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset || tx_rst)
    begin
      tbuf_full <= 1'b0;
      tbuf_last <= 1'b0;
      tbuf      <= '0;
      eom_arm   <= 1'b0;
    end
    else
    begin
      if (eom_cmd)
        eom_arm <= 1'b1;
      if (take)
        tbuf_full <= 1'b0;
      else if (txd_wr && !tbuf_full && tx_state_reg != ssf_pkg::SSF_TX_DIS)
      begin
        tbuf      <= i_pwdata[7:0];
        tbuf_full <= 1'b1;
        tbuf_last <= eom_arm || eom_cmd;
        eom_arm   <= 1'b0;
      end
    end
  end

  // Starve flag: set wins over the write-one clear
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset || ch_rst)
      tx_starve_flag <= 1'b0;
    else if (underrun)
      tx_starve_flag <= 1'b1;
    else if (apb_wr && i_paddr == `SSF_OFF_ST1 && i_pwdata[`SSF_ST1_STARVE])
      tx_starve_flag <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Transmit sequencer
  // ----------------------------------------------------------------
  logic [15:0] sh;
  logic [4:0]  cnt;
  logic [2:0]  ones;
  logic [15:0] crc;
  logic [15:0] crc_nx;
  logic        stuffing;
  logic        go;

  assign stuffing = ones == `SSF_STUFF_RUN;
  assign unit_end = tick && !stuffing && cnt == 5'h01 && tx_state_reg != ssf_pkg::SSF_TX_DIS;
  assign underrun = unit_end && tx_state_reg == ssf_pkg::SSF_TX_CHAR && !cur_last && !tbuf_full;
  assign go       = tbuf_full && !tx_starve_flag;
  assign take     = unit_end && tx_next == ssf_pkg::SSF_TX_CHAR;
  assign crc_nx   = crc_bit(crc, sh[0]);

  // Decision taken at the last bit of each unit on the line
  always_comb
  begin
    tx_next = tx_state_reg;
    case (tx_state_reg)
      ssf_pkg::SSF_TX_IDLE, ssf_pkg::SSF_TX_CFLAG, ssf_pkg::SSF_TX_ABORT:
        tx_next = go ? (hdlc ? ssf_pkg::SSF_TX_OFLAG : ssf_pkg::SSF_TX_SYN)
                     : ssf_pkg::SSF_TX_IDLE;
      ssf_pkg::SSF_TX_SYN, ssf_pkg::SSF_TX_OFLAG:
        tx_next = ssf_pkg::SSF_TX_CHAR;
      ssf_pkg::SSF_TX_CHAR:
        if (cur_last)
          tx_next = crc_en ? ssf_pkg::SSF_TX_FCS
                  : (hdlc ? ssf_pkg::SSF_TX_CFLAG : ssf_pkg::SSF_TX_IDLE);
        else if (tbuf_full)
          tx_next = ssf_pkg::SSF_TX_CHAR;
        else if (!hdlc)
          tx_next = (ctrl_reg[`SSF_CTRL_STARVE] && crc_en) ? ssf_pkg::SSF_TX_FCS
                  : ssf_pkg::SSF_TX_IDLE;
        else if (ctrl_reg[`SSF_CTRL_STARVE])
          tx_next = ssf_pkg::SSF_TX_ABORT;
        else
          tx_next = crc_en ? ssf_pkg::SSF_TX_FCS : ssf_pkg::SSF_TX_CFLAG;
      ssf_pkg::SSF_TX_FCS:
        tx_next = hdlc ? ssf_pkg::SSF_TX_CFLAG : ssf_pkg::SSF_TX_IDLE;
      default:
        tx_next = ssf_pkg::SSF_TX_DIS;
    endcase
  end

  // Shifter sends LSB first; the FCS is loaded reversed so it leaves MSB first
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset || tx_rst)
    begin
      tx_state_reg <= ssf_pkg::SSF_TX_DIS;
      sh           <= '0;
      cnt          <= '0;
      ones         <= '0;
      o_txd        <= 1'b1;
      cur_last     <= 1'b0;
      crc          <= `SSF_CRC_INIT;
    end
    else if (tx_state_reg == ssf_pkg::SSF_TX_DIS)
    begin
      o_txd <= 1'b1;
      if (tx_en)
      begin
        tx_state_reg <= ssf_pkg::SSF_TX_IDLE;
        sh  <= {8'h00, ctrl_reg[`SSF_CTRL_IDLE_SEL] ? idle_pattern_reg : 8'hff};
        cnt <= `SSF_BYTE_LEN;
      end
    end
    else if (tick)
    begin
      if (stuffing)
      begin
        o_txd <= 1'b0;
        ones  <= '0;
      end
      else
      begin
        o_txd <= sh[0];
        sh    <= sh >> 1;
        cnt   <= cnt - 5'h01;
        // Count ones only inside frame fields; flags and abort are never stuffed
        ones  <= (hdlc && sh[0] && (tx_state_reg == ssf_pkg::SSF_TX_CHAR
                 || tx_state_reg == ssf_pkg::SSF_TX_FCS)) ? ones + 3'h1 : 3'h0;
        if (tx_state_reg == ssf_pkg::SSF_TX_CHAR)
          crc <= crc_nx;
        if (unit_end)
        begin
          tx_state_reg <= tx_next;
          case (tx_next)
            ssf_pkg::SSF_TX_IDLE:
            begin
              sh  <= {8'h00, ctrl_reg[`SSF_CTRL_IDLE_SEL] ? idle_pattern_reg : 8'hff};
              cnt <= `SSF_BYTE_LEN;
            end
            ssf_pkg::SSF_TX_SYN:
            begin
              sh  <= {8'h00, sync_reg};
              cnt <= `SSF_BYTE_LEN;
              crc <= `SSF_CRC_INIT;
            end
            ssf_pkg::SSF_TX_OFLAG, ssf_pkg::SSF_TX_CFLAG:
            begin
              sh  <= {8'h00, `SSF_FLAG};
              cnt <= `SSF_BYTE_LEN;
              if (tx_next == ssf_pkg::SSF_TX_OFLAG)
                crc <= `SSF_CRC_INIT;
            end
            ssf_pkg::SSF_TX_CHAR:
            begin
              sh       <= {8'h00, tbuf};
              cnt      <= `SSF_BYTE_LEN;
              cur_last <= tbuf_last;
            end
            ssf_pkg::SSF_TX_FCS:
            begin
              sh  <= rev16(crc_nx);
              cnt <= `SSF_FCS_LEN;
            end
            ssf_pkg::SSF_TX_ABORT:
            begin
              sh  <= `SSF_ABORT;
              cnt <= `SSF_ABORT_LEN;
            end
            default:
            begin
              sh  <= '0;
              cnt <= '0;
            end
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive deframer
  // ----------------------------------------------------------------
  logic        rx_s1;
  logic        rx_s2;
  logic        b;
  ssf_pkg::ssf_rx_state_e rx_state_reg;
  logic [2:0]  rones;
  logic [6:0]  dl;
  logic [2:0]  dv;
  logic [7:0]  acc;
  logic [7:0]  win;
  logic [2:0]  nb;
  logic [7:0]  held;
  logic        held_v;
  logic        inframe;
  logic        res_pend;
  logic        pv;
  logic [7:0]  pd;
  ssf_pkg::ssf_rx_stat_t ps;

  // Line input crosses in through two flops
  always_ff @(posedge i_ref_clk)
  begin
    rx_s1 <= i_rxd;
    rx_s2 <= rx_s1;
  end
  assign b = rx_s2;

  // HDLC data is delayed seven bits so the leading part of a flag never reaches
  // the assembler; byte mode hunts the sync character and then never stops
  always_ff @(posedge i_ref_clk)
  begin
    pv <= 1'b0;
    if (i_reset || ch_rst)
    begin
      rx_state_reg <= ssf_pkg::SSF_RX_HUNT;
      {rones, dl, dv, acc, win, nb, held, held_v} <= '0;
      {inframe, res_pend, pd, ps} <= '0;
    end
    else if (res_pend)
    begin
      res_pend <= 1'b0;
      pv <= 1'b1;
      pd <= acc;
      ps <= 3'h6;
    end
    else if (tick && !hdlc)
    begin
      win <= {b, win[7:1]};
      if (rx_state_reg == ssf_pkg::SSF_RX_HUNT)
      begin
        nb <= '0;
        if ({b, win[7:1]} == sync_reg)
          rx_state_reg <= ssf_pkg::SSF_RX_DATA;
      end
      else
      begin
        acc <= {b, acc[7:1]};
        nb  <= nb + 3'h1;
        if (nb == 3'h7)
        begin
          pv <= 1'b1;
          pd <= {b, acc[7:1]};
          ps <= 3'h0;
        end
      end
    end
    else if (tick)
    begin
      rones <= b ? ((rones == 3'h7) ? rones : rones + 3'h1) : 3'h0;
      if (b && rones >= `SSF_FLAG_RUN)
      begin
        inframe <= 1'b0;
        held_v  <= 1'b0;
        dv      <= '0;
      end
      else if (!b && rones == `SSF_FLAG_RUN)
      begin
        // Closing flag: last whole byte ends the frame unless leftover bits follow it
        if (inframe && held_v)
        begin
          pv <= 1'b1;
          pd <= held;
          ps <= (nb == 3'h0) ? 3'h2 : 3'h0;
        end
        res_pend <= inframe && nb != 3'h0;
        inframe  <= 1'b1;
        held_v   <= 1'b0;
        dv       <= '0;
        nb       <= '0;
      end
      else if (!(!b && rones == `SSF_STUFF_RUN))
      begin
        dl <= {b, dl[6:1]};
        dv <= (dv == 3'h7) ? dv : dv + 3'h1;
        if (dv == 3'h7 && inframe)
        begin
          acc <= {dl[0], acc[7:1]};
          nb  <= nb + 3'h1;
          if (nb == 3'h7)
          begin
            held   <= {dl[0], acc[7:1]};
            held_v <= 1'b1;
            pv     <= held_v;
            pd     <= held;
            ps     <= 3'h0;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive buffer with status FIFO
  // ----------------------------------------------------------------
  logic full;
  assign full    = fcnt == (PW+1)'(RX_DEPTH);
  assign ovr_set = pv && full && !rx_pop;

  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset || ch_rst)
    begin
      rp   <= '0;
      wp   <= '0;
      fcnt <= '0;
    end
    else
    begin
      if (ovr_set)
      begin
        fifo_d[wp - PW'(1)] <= pd;
        fifo_s[wp - PW'(1)] <= {ps[2:1], 1'b1};
      end
      else if (pv)
      begin
        fifo_d[wp] <= pd;
        fifo_s[wp] <= ps;
        wp <= wp + PW'(1);
      end
      if (rx_pop)
        rp <= rp + PW'(1);
      fcnt <= fcnt + (PW+1)'(pv && !ovr_set) - (PW+1)'(rx_pop);
    end
  end

  // Overflow flag: set wins over the write-one clear
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset || ch_rst)
      rx_overflow_flag <= 1'b0;
    else if (ovr_set)
      rx_overflow_flag <= 1'b1;
    else if (apb_wr && i_paddr == `SSF_OFF_ST2 && i_pwdata[`SSF_ST2_OVERFLOW])
      rx_overflow_flag <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  sequence s_dis_held;
    tx_state_reg == ssf_pkg::SSF_TX_DIS ##1 tx_state_reg == ssf_pkg::SSF_TX_DIS;
  endsequence
  sequence s_mark_idle;
    tx_state_reg == ssf_pkg::SSF_TX_IDLE && tick && !stuffing && !ctrl_reg[`SSF_CTRL_IDLE_SEL]
      && $past(tx_state_reg) == ssf_pkg::SSF_TX_IDLE;
  endsequence

  property p_dis_mark;
    s_dis_held |-> o_txd && !tx_ready_flag;
  endproperty
  a_dis_mark: assert property (p_dis_mark) else $error("disabled line not marking");
  property p_idle_mark;
    s_mark_idle ##1 tx_state_reg == ssf_pkg::SSF_TX_IDLE |-> o_txd;
  endproperty
  a_idle_mark: assert property (p_idle_mark) else $error("idle mark broken");
  property p_stuff;
    tick && stuffing && tx_state_reg != ssf_pkg::SSF_TX_DIS && !tx_rst |=> !o_txd && ones == 3'h0;
  endproperty
  a_stuff: assert property (p_stuff) else $error("zero not inserted");
  property p_underrun;
    underrun && !ch_rst |=> tx_starve_flag && !tx_ready_flag;
  endproperty
  a_underrun: assert property (p_underrun) else $error("underrun not flagged");
  property p_starve_hold;
    tx_starve_flag && !(apb_wr && i_paddr == `SSF_OFF_ST1) && !ch_rst |=> tx_starve_flag;
  endproperty
  a_starve_hold: assert property (p_starve_hold) else $error("starve flag lost");
  property p_ovr_hold;
    rx_overflow_flag && !(apb_wr && i_paddr == `SSF_OFF_ST2) && !ch_rst |=> rx_overflow_flag;
  endproperty
  a_ovr_hold: assert property (p_ovr_hold) else $error("overflow flag lost");
  property p_ovr_set;
    ovr_set && !ch_rst |=> rx_overflow_flag && fcnt == (PW+1)'(RX_DEPTH);
  endproperty
  a_ovr_set: assert property (p_ovr_set) else $error("overrun not recorded");
  property p_starved_stay;
    tx_state_reg == ssf_pkg::SSF_TX_IDLE && tx_starve_flag && !tx_rst
      |=> tx_state_reg == ssf_pkg::SSF_TX_IDLE;
  endproperty
  a_starved_stay: assert property (p_starved_stay) else $error("left idle while starved");
  property p_abort_idle;
    unit_end && tx_state_reg == ssf_pkg::SSF_TX_ABORT && !tx_rst |=> tx_state_reg == ssf_pkg::SSF_TX_IDLE;
  endproperty
  a_abort_idle: assert property (p_abort_idle) else $error("abort not followed by idle");
endmodule : ssf_framer

// ===== verif/ssf_remote.sv
`timescale 1ns/1ps
// Remote station that hands our own line back one clock late.
// This keeps the line phase locked to the design's bit ticks.
module ssf_remote (
  input  wire logic i_ref_clk,
  input  wire logic i_line,
  output logic      o_line
);
  // Echo the line unchanged, so bit order and flags come back intact
  always_ff @(posedge i_ref_clk)
  begin
    o_line <= i_line;
  end
endmodule : ssf_remote

// ===== verif/tb.sv
`timescale 1ns/1ps
module tb;
  logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, err;
  logic        pready, pslverr, txd, rxd;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  int          error_cnt = 0, checked = 0;

  ssf_framer #(.BIT_DIV(2), .RX_DEPTH(4)) dut_u (.i_ref_clk(clk), .i_reset(rst), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_rxd(rxd), .o_txd(txd));
  ssf_remote far_u (.i_ref_clk(clk), .i_line(txd), .o_line(rxd));

  // Clock at 25 MHz
  initial forever #20 clk = ~clk;

  task automatic report_and_stop();
    $display("errors=%0d checks=%0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1; pen <= 0; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 0; pen <= 0;
  endtask : apb

  // Poll a register until masked bits match, bounded
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    for (int i = 0; i < 3000 && (q & m) !== v; i++)
      apb(0, a, 0);
    chk(q & m, v);
  endtask : poll

  // Fresh channel in a given mode, transmitter enabled
  task automatic start(input logic [31:0] mode, input logic [31:0] ctl);
    apb(1, 8'h08, 32'h8);
    apb(1, 8'h04, mode);
    apb(1, 8'h00, ctl);
    apb(1, 8'h08, 32'h2);
  endtask : start

  task automatic t_reset();
    chk(txd, 1);
    apb(0, 8'h18, 0);
    chk(q[0], 0);
    apb(0, 8'h80, 0);
    chk(err, 1);
    chk(q, 0);
  endtask : t_reset

  // Idle pattern equal to the sync character: the byte receiver locks onto it
  task automatic t_idle();
    apb(1, 8'h0c, 32'h96);
    start(0, 1);
    apb(0, 8'h18, 0);
    chk(q[0], 1);
    poll(8'h18, 2, 2);
    apb(0, 8'h24, 0);
    chk(q & 32'h8000_07ff, 32'h8000_0096);
  endtask : t_idle

  task automatic t_byte();
    start(0, 0);
    apb(1, 8'h14, 32'h5a);
    q = 0;
    poll(8'h1c, 1, 1);
    apb(0, 8'h18, 0);
    chk(q[0], 0);
    poll(8'h18, 2, 2);
    apb(0, 8'h24, 0);
    chk(q & 32'h8000_07ff, 32'h8000_005a);
    apb(1, 8'h1c, 1);
    apb(0, 8'h1c, 0);
    chk(q, 0);
    q = 0;
    poll(8'h20, 1, 1);
  endtask : t_byte

  task automatic t_hdlc();
    start(32'h2, 0);
    apb(1, 8'h08, 32'h4);
    apb(1, 8'h14, 32'hfc);
    q = 0;
    poll(8'h18, 2, 2);
    apb(0, 8'h24, 0);
    chk(q & 32'h8000_07ff, 32'h8000_02fc);
    apb(0, 8'h1c, 0);
    chk(q, 0);
    // CRC of 3c from all ones is 162f; sent MSB first it is received as 68, f4
    start(32'ha, 0);
    apb(1, 8'h08, 32'h4);
    apb(1, 8'h14, 32'h3c);
    for (int i = 0; i < 3; i++)
    begin
      q = 0;
      poll(8'h18, 2, 2);
      apb(0, 8'h24, 0);
      chk(q & 32'h8000_07ff, (i == 0) ? 32'h8000_003c : (i == 1) ? 32'h8000_0068 : 32'h8000_02f4);
    end
    apb(0, 8'h1c, 0);
    chk(q, 0);
  endtask : t_hdlc

  task automatic t_abort();
    start(32'h2, 32'h2);
    apb(1, 8'h14, 32'h81);
    q = 0;
    poll(8'h1c, 1, 1);
    repeat (200) @(posedge clk);
    apb(0, 8'h18, 0);
    chk(q[1], 0);
    // Without starve control the starved frame closes normally
    start(32'h2, 0);
    apb(1, 8'h14, 32'h81);
    q = 0;
    poll(8'h18, 2, 2);
    apb(0, 8'h24, 0);
    chk(q & 32'h8000_07ff, 32'h8000_0281);
    apb(0, 8'h1c, 0);
    chk(q, 1);
  endtask : t_abort

  // Watchdog well past the expected run time
  initial
  begin
    #(40 * 60000);
    error_cnt++;
    report_and_stop();
  end

  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 0;
    t_reset();
    t_idle();
    t_byte();
    t_hdlc();
    t_abort();
    report_and_stop();
  end
endmodule : tb
